// ---- hdl/port_latch_pkg.sv ----
// Purpose: Shared constants and carriers for the port latch bank
// Assumes: 8-bit port access from the CPU side
// Notes: Access kinds are encoded as an enum
package port_latch_pkg;
    // ==================================================
    // Widths and reset values
    localparam int PORT_WIDTH = 8;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'h00; // All pins input
    localparam logic [7:0] ALU_RESULT_RESET = 8'h00;

    // ==================================================
    // CPU access kinds
    typedef enum logic [2:0] {
        ACC_NONE = 3'b000,
        ACC_WRITE = 3'b001,
        ACC_READ = 3'b010,
        ACC_RMW_AND = 3'b011,
        ACC_RMW_OR = 3'b100,
        ACC_RMW_XOR = 3'b101,
        ACC_DIR_WRITE = 3'b110,
        ACC_DIR_READ = 3'b111
    } access_e;

    // ==================================================
    // CPU request carrier
    typedef struct packed {
        access_e kind;
        logic [7:0] data;
    } cpu_req_s;
endpackage

// ---- hdl/port_latch_read_write_logic.sv ----
// Purpose: One 8-bit I/O port: output latch, direction, CPU access
// Assumes: CPU requests are single-cycle strobes on clk_i
// Notes: All accesses are byte wide; read data is registered
//
// Operation
// - Output mode: write loads latch, pin drives it
// - Latch holds value until next write
// - Input mode: write updates latch, pin unaffected
// - Output mode read returns latch, unaltered
// - Input mode read returns pin level
// - Reads never modify the latch
// - Output mode RMW works on latch, drives result
// - Input mode RMW latch may become undefined
// - Bit operations are full byte accesses
`timescale 1ns/1ps
`default_nettype none
module port_latch_read_write_logic
    import port_latch_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // CPU access
    input wire cpu_req_s req_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    // Pins
    input wire logic [7:0] pin_in_i,
    output logic [7:0] pin_out_o,
    output logic [7:0] pin_oe_o
);
    // ==================================================
    // Elaboration check
    if (PORT_WIDTH != 8) begin : g_width_check
        $error("port width must be 8");
    end

    // ==================================================
    // State
    logic [7:0] pin_meta_reg;
    logic [7:0] pin_sync_reg;
    logic [7:0] latch_reg;
    logic [7:0] latch_next;
    logic [7:0] dir_reg;
    logic [7:0] view;
    logic [7:0] rmw_value;

    // Read view and arithmetic source share one byte-wide path.
    // Output bits take the latch, input bits the synchronised pin.
    // An arithmetic access on a mixed port therefore combines the pin
    // level with the operand into the latch of every input bit. Software
    // must treat those latch bits as undefined and rewrite them
    // before it turns those pins into outputs.
    // The pin level is seen two clocks late through the synchroniser,
    // so a read right after a pin change still returns the old level.
    // Pin drivers follow latch_next and the direction write directly,
    // so the pins change on the same edge as the stored state.
    // Only the first synchroniser stage reads the raw pin; all logic
    // reads the second stage.
    // Direction resets to all input, so no pin drives after reset.
    // Read data holds its value until the next read of either kind.

    // Byte-wide operation on a source byte
    function automatic logic [7:0] alu_op(input access_e k, input logic [7:0] a, input logic [7:0] b);
        case (k)
            ACC_RMW_AND: alu_op = a & b;
            ACC_RMW_OR: alu_op = a | b;
            ACC_RMW_XOR: alu_op = a ^ b;
            default: alu_op = ALU_RESULT_RESET;
        endcase
    endfunction

    // Two-stage pin synchroniser
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_meta_reg <= LATCH_RESET;
            pin_sync_reg <= LATCH_RESET;
        end else begin
            pin_meta_reg <= pin_in_i;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // Read view: latch for output pins, pin for input pins
    always_comb begin
        view = (dir_reg & latch_reg) | (~dir_reg & pin_sync_reg);
        rmw_value = alu_op(req_i.kind, view, req_i.data);
    end

    // Next latch value
    always_comb begin
        case (req_i.kind)
            ACC_WRITE: latch_next = req_i.data;
            ACC_RMW_AND, ACC_RMW_OR, ACC_RMW_XOR: latch_next = rmw_value;
            default: latch_next = latch_reg;
        endcase
    end

    // Output latch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch_reg <= LATCH_RESET;
        end else begin
            latch_reg <= latch_next;
        end
    end

    // Direction register, 1 = output
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dir_reg <= DIR_RESET;
        end else if (req_i.kind == ACC_DIR_WRITE) begin
            dir_reg <= req_i.data;
        end
    end

    // Pin drivers, registered from next-state values
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_out_o <= LATCH_RESET;
            pin_oe_o <= DIR_RESET;
        end else begin
            pin_out_o <= latch_next;
            pin_oe_o <= (req_i.kind == ACC_DIR_WRITE) ? req_i.data : dir_reg;
        end
    end

    // Registered read data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= LATCH_RESET;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= (req_i.kind == ACC_READ) || (req_i.kind == ACC_DIR_READ);
            if (req_i.kind == ACC_READ) begin
                rdata_o <= view;
            end else if (req_i.kind == ACC_DIR_READ) begin
                rdata_o <= dir_reg;
            end
        end
    end

    // ==================================================
    // Assertions
    AST_WRITE_LOADS: assert property (@(posedge clk_i) disable iff (rst_i)
        req_i.kind == ACC_WRITE |=> latch_reg == $past(req_i.data))
        else $error("write did not load latch");
    AST_OUT_DRIVES: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> pin_out_o == latch_reg)
        else $error("pin output differs from latch");
    AST_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        req_i.kind inside {ACC_NONE, ACC_DIR_WRITE, ACC_DIR_READ} |=> $stable(latch_reg))
        else $error("latch changed without write");
    AST_INPUT_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> pin_oe_o == dir_reg)
        else $error("buffer enable differs from direction");
    AST_READ_OUT: assert property (@(posedge clk_i) disable iff (rst_i)
        req_i.kind == ACC_READ |=> rvalid_o && ((rdata_o & dir_reg) == (latch_reg & dir_reg)))
        else $error("output pin read not latch");
    AST_READ_IN: assert property (@(posedge clk_i) disable iff (rst_i)
        req_i.kind == ACC_READ |=> (rdata_o & ~dir_reg) == ($past(pin_sync_reg) & ~dir_reg))
        else $error("input pin read not pin level");
    AST_READ_KEEP: assert property (@(posedge clk_i) disable iff (rst_i)
        req_i.kind == ACC_READ |=> latch_reg == $past(latch_reg))
        else $error("read modified latch");
    AST_RMW_OUT: assert property (@(posedge clk_i) disable iff (rst_i)
        req_i.kind == ACC_RMW_OR |=> ((latch_reg & dir_reg) == (($past(latch_reg) | $past(req_i.data)) & dir_reg)))
        else $error("rmw result wrong on output pins");
    AST_RMW_BYTE: assert property (@(posedge clk_i) disable iff (rst_i)
        req_i.kind == ACC_RMW_AND |=> latch_reg == ($past(view) & $past(req_i.data)))
        else $error("rmw not byte wide from read view");

    // Arithmetic never switches a buffer on
    AST_RMW_PIN_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
        req_i.kind inside {ACC_RMW_AND, ACC_RMW_OR, ACC_RMW_XOR} |=> pin_oe_o == $past(dir_reg))
        else $error("rmw changed buffer enable");

    // Direction write loads register and enables
    AST_DIR_LOADS: assert property (@(posedge clk_i) disable iff (rst_i)
        req_i.kind == ACC_DIR_WRITE |=> dir_reg == $past(req_i.data) && pin_oe_o == $past(req_i.data))
        else $error("direction write not applied");

    // Read strobe only after a read request
    AST_RVALID_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
        !(req_i.kind inside {ACC_READ, ACC_DIR_READ}) |=> !rvalid_o)
        else $error("read valid without read");

    // Exclusive or on output bits uses the latch
    AST_RMW_XOR_OUT: assert property (@(posedge clk_i) disable iff (rst_i)
        req_i.kind == ACC_RMW_XOR |=> ((latch_reg & dir_reg) == (($past(latch_reg) ^ $past(req_i.data)) & dir_reg)))
        else $error("xor result wrong on output pins");

    // And on output bits uses the latch
    AST_RMW_AND_OUT: assert property (@(posedge clk_i) disable iff (rst_i)
        req_i.kind == ACC_RMW_AND |=> ((latch_reg & dir_reg) == (($past(latch_reg) & $past(req_i.data)) & dir_reg)))
        else $error("and result wrong on output pins");

    // Direction read returns the direction byte
    AST_DIR_READ: assert property (@(posedge clk_i) disable iff (rst_i)
        req_i.kind == ACC_DIR_READ |=> rvalid_o && rdata_o == dir_reg)
        else $error("direction read wrong");

    // Read data holds between reads
    AST_RDATA_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        !(req_i.kind inside {ACC_READ, ACC_DIR_READ}) |=> $stable(rdata_o))
        else $error("read data changed without read");

    // Write reaches the pin driver
    AST_WRITE_PIN: assert property (@(posedge clk_i) disable iff (rst_i)
        req_i.kind == ACC_WRITE |=> pin_out_o == $past(req_i.data))
        else $error("write did not reach pin driver");

    // Write leaves buffer enables alone
    AST_WRITE_OE_KEEP: assert property (@(posedge clk_i) disable iff (rst_i)
        req_i.kind == ACC_WRITE |=> pin_oe_o == $past(pin_oe_o))
        else $error("write changed buffer enable");

    // Read leaves pin drivers alone
    AST_READ_PIN_KEEP: assert property (@(posedge clk_i) disable iff (rst_i)
        req_i.kind == ACC_READ |=> $stable(pin_out_o))
        else $error("read changed pin driver");
endmodule
`default_nettype wire

// ---- bench/port_latch_read_write_logic_tb_top.sv ----
// Purpose: Self-checking bench for the 8-bit port latch bank
// Assumes: Requests are driven at the falling edge, one at a time
// Notes: Fixed stimulus only; pins are driven by the bench
`timescale 1ns/1ps
`default_nettype none
module port_latch_read_write_logic_tb_top
    import port_latch_pkg::*;
;
    // ==================================================
    // Stimulus and observed signals
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    cpu_req_s req_i;
    logic [7:0] pin_in_i, rdata_o, pin_out_o, pin_oe_o;
    logic rvalid_o;
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;

    // Clock at 4 ns period
    always #2 clk_i = ~clk_i;

    port_latch_read_write_logic i_port_latch_read_write_logic (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i),
        .rdata_o(rdata_o), .rvalid_o(rvalid_o), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o));

    // ==================================================
    // Shared tasks
    task automatic give_verdict();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, e, g);
        end
    endtask

    // One request for one edge, then idle
    task automatic op(input access_e k, input logic [7:0] d);
        @(negedge clk_i);
        req_i = '{k, d};
        @(negedge clk_i);
        req_i = '{ACC_NONE, 8'h00};
    endtask

    // Read and judge in the cycle that rvalid stands
    task automatic rd(input access_e k, input logic [7:0] e, input string what);
        op(k, 8'h00);
        chk("rvalid", 8'h01, {7'h00, rvalid_o});
        chk(what, e, rdata_o);
    endtask

    // ==================================================
    // Scenarios
    task automatic t_reset();
        chk("oe", 8'h00, pin_oe_o);
        chk("out", 8'h00, pin_out_o);
        rd(ACC_DIR_READ, 8'h00, "dir");
    endtask

    // Input mode write, then switch to output
    task automatic t_in_write();
        op(ACC_WRITE, 8'hA5);
        chk("oe", 8'h00, pin_oe_o);
        rd(ACC_READ, 8'h3C, "pin read");
        op(ACC_DIR_WRITE, 8'hFF);
        chk("oe", 8'hFF, pin_oe_o);
        chk("out", 8'hA5, pin_out_o);
        rd(ACC_READ, 8'hA5, "latch read");
        rd(ACC_READ, 8'hA5, "latch reread");
        op(ACC_WRITE, 8'h5A);
        chk("out", 8'h5A, pin_out_o);
    endtask

    // Byte-wide arithmetic on the latch
    task automatic t_rmw();
        op(ACC_RMW_AND, 8'h0F);
        chk("and", 8'h0A, pin_out_o);
        op(ACC_RMW_OR, 8'hF0);
        chk("or", 8'hFA, pin_out_o);
        op(ACC_RMW_XOR, 8'hFF);
        chk("xor", 8'h05, pin_out_o);
    endtask

    // Mixed directions: input bits pick up the pin level
    task automatic t_mixed();
        @(negedge clk_i);
        pin_in_i = 8'hA0;
        op(ACC_DIR_WRITE, 8'h0F);
        op(ACC_RMW_OR, 8'h01);
        chk("mixed", 8'hA5, pin_out_o);
        chk("oe", 8'h0F, pin_oe_o);
        op(ACC_WRITE, 8'hA5);
        op(ACC_DIR_WRITE, 8'hFF);
        rd(ACC_READ, 8'hA5, "mixed read");
    endtask

    // Hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            give_verdict();
        end
    end

    initial begin
        req_i = '{ACC_NONE, 8'h00};
        pin_in_i = 8'h3C;
        repeat (8) @(negedge clk_i);
        rst_i = 1'b0;
        t_reset();
        t_in_write();
        t_rmw();
        t_mixed();
        give_verdict();
    end
endmodule
`default_nettype wire
